// [core/ftid_defs.vh]
// Constants for the fourteen-bit instruction decoder.
`ifndef FTID_DEFS_VH
`define FTID_DEFS_VH
`define FTID_IW          14
`define FTID_CLS_HI      13
`define FTID_CLS_LO      12
`define FTID_CLS_BYTE    2'h0
`define FTID_CLS_BIT     2'h1
`define FTID_CLS_JUMP    2'h2
`define FTID_CLS_LIT     2'h3
`define FTID_DEST_BIT    7
`define FTID_FILE_HI     6
`define FTID_BSEL_HI     9
`define FTID_BSEL_LO     7
`define FTID_BOP_HI      11
`define FTID_BOP_LO      10
`define FTID_BYOP_HI     11
`define FTID_BYOP_LO     8
`define FTID_K8_HI       7
`define FTID_K11_HI      10
`define FTID_GOTO_BIT    11
`define FTID_BOP_BTFSC   2'h2
`define FTID_BOP_BTFSS   2'h3
`define FTID_BY_DECFSZ   4'hB
`define FTID_BY_INCFSZ   4'hF
`define FTID_BY_MOVWF    4'h0
`define FTID_BY_CLR      4'h1
`define FTID_LIT_RET_HI  11
`define FTID_LIT_RET_LO  10
`define FTID_LIT_RETLW   2'h1
`define FTID_CTL_RETURN  8'h08
`define FTID_CTL_RETFIE  8'h09
`define FTID_CTL_OPTION  8'h62
`define FTID_CTL_TRISTATE_LOAD_INSTRUCTION_LO 8'h65
`define FTID_CTL_TRISTATE_LOAD_INSTRUCTION_HI 8'h67
`define FTID_TIMER_ZERO_REGISTER_ADDR   7'h01
`define FTID_PHASES      4
`define FTID_PH_W        2
`endif

// [core/ftid_phase_gen.v]
// Four-phase instruction cycle generator, one oscillator period per phase.
`timescale 1ns/1ps
`include "ftid_defs.vh"
module ftid_phase_gen #(
	parameter PHASES = `FTID_PHASES
) (
	clock,
	rst_n,
	phase_onehot
);
	input  wire               clock;
	input  wire               rst_n;
	output reg  [PHASES-1:0]  phase_onehot;

	// A rotating one-hot ring; phase 1 follows reset.
	always @(posedge clock or negedge rst_n) begin // see [RQ10]
		if (!rst_n) begin
			phase_onehot <= {{(PHASES-1){1'b0}}, 1'b1};
		end else begin
			phase_onehot <= {phase_onehot[PHASES-2:0], phase_onehot[PHASES-1]};
		end
	end
endmodule

// [core/ftid_decoder.v]
// Fourteen-bit instruction decoder with four-phase cycle timing.
// Notes on behaviour
// [RQ1] Each instruction is one 14-bit word: opcode part plus operand fields.
// [RQ2] Every word is sorted into byte, bit, or literal and control class.
// [RQ3] Byte operation with destination bit zero writes the accumulator only.
// [RQ4] Byte operation with destination bit one writes the addressed file register.
// [RQ5] File address is seven bits, 0x00 to 0x7F, used as source and destination.
// [RQ6] Bit number selects one bit of the eight-bit addressed file register.
// [RQ7] Literal is eight bits for data, eleven bits for jump and call targets.
// [RQ8] An instruction takes one cycle unless a test is true or counter changes.
// [RQ9] Then it takes two cycles; the second is a no-operation flushing prefetch.
// [RQ10] One instruction cycle is four oscillator periods in four phases.
// [RQ11] Don't-care opcode bits are ignored; software should fill them with zero.
// [RQ12] Software should avoid option-load and tristate-load; they still execute.
// [RQ13] Port self-modification reads pin values, not output latches.
// [RQ14] Timer-zero write-back clears the prescaler when it is assigned there.
// [RQ15] Byte format: destination in bit 7, file address in bits 6 to 0.
`timescale 1ns/1ps
`include "ftid_defs.vh"
module ftid_decoder #(
	parameter IW = `FTID_IW
) (
	clock,
	rst_n,
	instr_word,
	instr_valid,
	skip_cond_true,
	file_is_port,
	prescaler_to_timer,
	phase_out,
	cycle_start,
	instr_class,
	file_addr,
	bit_sel,
	literal8,
	literal11,
	dest_accum,
	dest_file,
	byte_op,
	bit_op,
	use_pin_source,
	prescaler_clear,
	pc_change,
	second_cycle_nop,
	tristate_load_instruction,
	option_load,
	fetch_strobe
);
	input  wire          clock;
	input  wire          rst_n;
	input  wire [IW-1:0] instr_word;
	input  wire          instr_valid;
	input  wire          skip_cond_true;
	input  wire          file_is_port;
	input  wire          prescaler_to_timer;
	output reg  [3:0]    phase_out;
	output reg           cycle_start;
	output reg  [1:0]    instr_class;
	output reg  [6:0]    file_addr;
	output reg  [2:0]    bit_sel;
	output reg  [7:0]    literal8;
	output reg  [10:0]   literal11;
	output reg           dest_accum;
	output reg           dest_file;
	output reg  [3:0]    byte_op;
	output reg  [1:0]    bit_op;
	output reg           use_pin_source;
	output reg           prescaler_clear;
	output reg           pc_change;
	output reg           second_cycle_nop;
	output reg           tristate_load_instruction;
	output reg           option_load;
	output reg           fetch_strobe;

	localparam ST_EXEC = 2'b01;
	localparam ST_FLSH = 2'b10;

	wire [`FTID_PHASES-1:0] phase;
	reg  [1:0]              state_reg;
	reg  [1:0]              state_next;
	reg  [IW-1:0]           latched_reg;

	// Class from the two top bits; the remaining bits hold the operation and operand fields.
	function [1:0] class_of;
		input [IW-1:0] w;
		begin
			class_of = w[`FTID_CLS_HI:`FTID_CLS_LO]; // see [RQ1] see [RQ2]
		end
	endfunction

	// True for words whose operation alters the program counter on its own.
	function changes_pc;
		input [IW-1:0] w;
		begin
			case (class_of(w))
				`FTID_CLS_JUMP: changes_pc = 1'b1;
				`FTID_CLS_LIT: changes_pc =
					(w[`FTID_LIT_RET_HI:`FTID_LIT_RET_LO] == `FTID_LIT_RETLW);
				`FTID_CLS_BYTE: changes_pc =
					(w[`FTID_BYOP_HI:`FTID_K8_HI+1] == 4'h0) &&
					((w[`FTID_K8_HI:0] == `FTID_CTL_RETURN) ||
					 (w[`FTID_K8_HI:0] == `FTID_CTL_RETFIE));
				default: changes_pc = 1'b0;
			endcase
		end
	endfunction

	// True for conditional-skip words.
	function is_skip;
		input [IW-1:0] w;
		begin
			if (class_of(w) == `FTID_CLS_BIT) begin
				is_skip = w[`FTID_BOP_HI];
			end else if (class_of(w) == `FTID_CLS_BYTE) begin
				is_skip = (w[`FTID_BYOP_HI:`FTID_BYOP_LO] == `FTID_BY_DECFSZ) ||
					(w[`FTID_BYOP_HI:`FTID_BYOP_LO] == `FTID_BY_INCFSZ);
			end else begin
				is_skip = 1'b0;
			end
		end
	endfunction

	// True for byte words that write a result (any destination-select form).
	function byte_writes;
		input [IW-1:0] w;
		begin
			byte_writes = (w[`FTID_BYOP_HI:`FTID_BYOP_LO] != `FTID_BY_MOVWF) ||
				w[`FTID_DEST_BIT];
		end
	endfunction

	ftid_phase_gen #(
		.PHASES(`FTID_PHASES)
	) u_phase (
		.clock        (clock),
		.rst_n        (rst_n),
		.phase_onehot (phase)
	);

	// Word is latched in the last phase and decoded from the first phase on.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			latched_reg <= {IW{1'b0}};
		end else if (phase[`FTID_PHASES-1] && instr_valid) begin
			latched_reg <= instr_word;
		end else if (phase[`FTID_PHASES-1]) begin
			latched_reg <= {IW{1'b0}};
		end
	end

	// The skip condition is sampled at the last phase, one phase after the write phase.
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_EXEC: begin
				if (phase[`FTID_PHASES-1] &&
					(changes_pc(latched_reg) || (is_skip(latched_reg) && skip_cond_true))) begin
					state_next = ST_FLSH; // see [RQ9]
				end
			end
			ST_FLSH: begin
				if (phase[`FTID_PHASES-1]) begin
					state_next = ST_EXEC; // see [RQ8]
				end
			end
			default: state_next = ST_EXEC;
		endcase
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_EXEC;
		end else begin
			state_reg <= state_next;
		end
	end

	// Decoded fields are registered once per cycle at phase one; the prescaler clear is set at the write phase.
	// Reserved words in the control space simply decode to no action.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase_out                 <= 4'h1;
			cycle_start               <= 1'b0;
			fetch_strobe              <= 1'b0;
			instr_class               <= `FTID_CLS_BYTE;
			file_addr                 <= 7'h00;
			bit_sel                   <= 3'h0;
			literal8                  <= 8'h00;
			literal11                 <= 11'h000;
			dest_accum                <= 1'b0;
			dest_file                 <= 1'b0;
			byte_op                   <= 4'h0;
			bit_op                    <= 2'h0;
			use_pin_source            <= 1'b0;
			prescaler_clear           <= 1'b0;
			pc_change                 <= 1'b0;
			second_cycle_nop          <= 1'b0;
			tristate_load_instruction <= 1'b0;
			option_load               <= 1'b0;
		end else begin
			phase_out    <= {phase[`FTID_PHASES-2:0], phase[`FTID_PHASES-1]}; // see [RQ10]
			cycle_start  <= phase[`FTID_PHASES-1];
			fetch_strobe <= phase[`FTID_PHASES-1] && (state_next == ST_EXEC);
			prescaler_clear <= 1'b0;
			// Raised with the cleared destinations so a flush never shows stale writes.
			if (phase[0]) begin
				second_cycle_nop <= (state_reg == ST_FLSH); // see [RQ9]
			end
			if (phase[0] && state_reg == ST_EXEC) begin
				instr_class <= class_of(latched_reg); // see [RQ2]
				file_addr   <= latched_reg[`FTID_FILE_HI:0]; // see [RQ5] see [RQ15]
				bit_sel     <= latched_reg[`FTID_BSEL_HI:`FTID_BSEL_LO]; // see [RQ6]
				literal8    <= latched_reg[`FTID_K8_HI:0]; // see [RQ7]
				literal11   <= latched_reg[`FTID_K11_HI:0]; // see [RQ7]
				byte_op     <= latched_reg[`FTID_BYOP_HI:`FTID_BYOP_LO];
				bit_op      <= latched_reg[`FTID_BOP_HI:`FTID_BOP_LO];
				pc_change   <= changes_pc(latched_reg); // see [RQ8]
				// Bits 11 to 8 must be zero and the whole low byte must match exactly.
				option_load <= (class_of(latched_reg) == `FTID_CLS_BYTE) &&
					(latched_reg[`FTID_BYOP_HI:`FTID_K8_HI+1] == 4'h0) &&
					(latched_reg[`FTID_K8_HI:0] == `FTID_CTL_OPTION); // see [RQ11] see [RQ12]
				tristate_load_instruction <= (class_of(latched_reg) == `FTID_CLS_BYTE) &&
					(latched_reg[`FTID_BYOP_HI:`FTID_K8_HI+1] == 4'h0) &&
					(latched_reg[`FTID_K8_HI:0] >= `FTID_CTL_TRISTATE_LOAD_INSTRUCTION_LO) &&
					(latched_reg[`FTID_K8_HI:0] <= `FTID_CTL_TRISTATE_LOAD_INSTRUCTION_HI); // see [RQ12]
				if (class_of(latched_reg) == `FTID_CLS_BYTE && byte_writes(latched_reg)) begin
					dest_accum <= ~latched_reg[`FTID_DEST_BIT]; // see [RQ3]
					dest_file  <= latched_reg[`FTID_DEST_BIT]; // see [RQ4] see [RQ15]
					use_pin_source <= file_is_port; // see [RQ13]
				end else if (class_of(latched_reg) == `FTID_CLS_BIT) begin
					dest_accum <= 1'b0;
					dest_file  <= ~latched_reg[`FTID_BOP_HI]; // see [RQ6]
					use_pin_source <= file_is_port && ~latched_reg[`FTID_BOP_HI]; // see [RQ13]
				end else begin
					dest_accum <= (class_of(latched_reg) == `FTID_CLS_LIT);
					dest_file  <= 1'b0;
					use_pin_source <= 1'b0;
				end
			end else if (phase[0]) begin
				// Flush cycle: the prefetched word is discarded as a no-operation.
				dest_accum     <= 1'b0; // see [RQ9]
				dest_file      <= 1'b0;
				use_pin_source <= 1'b0;
				pc_change      <= 1'b0;
				option_load    <= 1'b0;
				tristate_load_instruction <= 1'b0;
			end
			// The clear fires at the write phase so the prescaler and timer agree.
			if (phase[`FTID_PH_W] && dest_file && prescaler_to_timer &&
				file_addr == `FTID_TIMER_ZERO_REGISTER_ADDR) begin
				prescaler_clear <= 1'b1; // see [RQ14]
			end
		end
	end
endmodule

// [verif/ftid_chk.sv]
// Concurrent checks on the decoder ports.
`timescale 1ns/1ps
`include "ftid_defs.vh"
module ftid_chk (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       prescaler_to_timer,
	input wire logic [3:0] phase_out,
	input wire logic       cycle_start,
	input wire logic       fetch_strobe,
	input wire logic [1:0] instr_class,
	input wire logic [6:0] file_addr,
	input wire logic       dest_accum,
	input wire logic       dest_file,
	input wire logic       prescaler_clear,
	input wire logic       second_cycle_nop
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence s_ring;
		phase_out[1] ##1 phase_out[2] ##1 phase_out[3] ##1 phase_out[0];
	endsequence
	sequence s_flush;
		second_cycle_nop [*4] ##1 !second_cycle_nop;
	endsequence
	a_phase_ring: assert property (phase_out[0] |=> s_ring) else $error("phase ring");
	a_start_phase: assert property (cycle_start |-> phase_out == 4'h1) else $error("start");
	a_fetch_phase: assert property (fetch_strobe |-> phase_out == 4'h1) else $error("fetch");
	a_dest_single: assert property (!(dest_accum && dest_file)) else $error("two dests");
	a_flush_quiet: assert property (second_cycle_nop |-> !dest_accum && !dest_file)
		else $error("flush writes");
	// A flush lasts exactly one instruction cycle and never chains into a second one.
	a_flush_len: assert property ($rose(second_cycle_nop) |-> s_flush) else $error("flush len");
	a_psc_cause: assert property (prescaler_clear |-> file_addr == `FTID_TIMER_ZERO_REGISTER_ADDR && prescaler_to_timer)
		else $error("psc cause");
	a_psc_due: assert property (phase_out[3] && prescaler_to_timer && instr_class == 2'h0 && dest_file
		&& file_addr == `FTID_TIMER_ZERO_REGISTER_ADDR |-> (prescaler_clear || $past(prescaler_clear)
		|| $past(prescaler_clear, 2)) or ##1 prescaler_clear) else $error("psc missing");
endmodule
bind ftid_decoder ftid_chk u_chk (
	.clock(clock), .rst_n(rst_n), .prescaler_to_timer(prescaler_to_timer),
	.phase_out(phase_out), .cycle_start(cycle_start), .fetch_strobe(fetch_strobe),
	.instr_class(instr_class), .file_addr(file_addr), .dest_accum(dest_accum),
	.dest_file(dest_file), .prescaler_clear(prescaler_clear), .second_cycle_nop(second_cycle_nop)
);

// [verif/ftid_prog_mem.sv]
// Program memory model that hands one instruction word per fetch.
`timescale 1ns/1ps
module ftid_prog_mem (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        fetch_strobe,
	input wire logic        idle,
	input wire logic [13:0] next_word,
	output logic     [13:0] instr_word,
	output logic            instr_valid
);
	logic [13:0] word_reg;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			word_reg <= 14'h0000;
		else if (fetch_strobe)
			word_reg <= next_word;
	end
	// A released bus shows the inverse of its last word so a stale value is never mistaken.
	assign instr_valid = !idle;
	assign instr_word = idle ? ~word_reg : word_reg;
endmodule

// [verif/tb_fourteen_bit_instruction_decode.sv]
// Random and corner-case bench for the instruction decoder.
`timescale 1ns/1ps
module tb_fourteen_bit_instruction_decode;
	reg         clock, rst_n, skip_cond_true, file_is_port, prescaler_to_timer;
	reg         idle, fetched, flush_cur, port_s;
	reg  [13:0] next_word, exec_w, w;
	reg  [15:0] lfsr;
	reg  [13:0] corner [0:13];
	wire [13:0] instr_word;
	wire [3:0]  phase_out, byte_op;
	wire [1:0]  instr_class, bit_op;
	wire [6:0]  file_addr;
	wire [2:0]  bit_sel;
	wire [7:0]  literal8;
	wire [10:0] literal11;
	wire        instr_valid, dest_accum, dest_file, pc_change, second_cycle_nop;
	wire        tristate_load_instruction, option_load, fetch_strobe, use_pin_source;
	integer     error_cnt, comparisons, lat_cnt, n, i;
	ftid_prog_mem u_mem (.clock(clock), .rst_n(rst_n), .fetch_strobe(fetch_strobe), .idle(idle),
		.next_word(next_word), .instr_word(instr_word), .instr_valid(instr_valid));
	ftid_decoder u_dut (.clock(clock), .rst_n(rst_n), .instr_word(instr_word),
		.instr_valid(instr_valid), .skip_cond_true(skip_cond_true), .file_is_port(file_is_port),
		.prescaler_to_timer(prescaler_to_timer), .phase_out(phase_out), .cycle_start(),
		.instr_class(instr_class), .file_addr(file_addr), .bit_sel(bit_sel), .literal8(literal8),
		.literal11(literal11), .dest_accum(dest_accum), .dest_file(dest_file), .byte_op(byte_op),
		.bit_op(bit_op), .use_pin_source(use_pin_source), .prescaler_clear(), .pc_change(pc_change),
		.second_cycle_nop(second_cycle_nop), .tristate_load_instruction(tristate_load_instruction),
		.option_load(option_load), .fetch_strobe(fetch_strobe));
	function automatic [15:0] lfsr_step(input [15:0] x);
		lfsr_step = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic is_br(input [13:0] x);
		is_br = x[13:12] == 2'h2 || x == 14'h0008 || x == 14'h0009 || x[13:10] == 4'hD;
	endfunction
	function automatic is_sk(input [13:0] x);
		is_sk = x[13:8] == 6'h0B || x[13:8] == 6'h0F || x[13:11] == 3'h3;
	endfunction
	task chk_f(input [11:0] got, input [11:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("ERROR %0t field %h expected %h", $time, got, exp);
		end
	endtask
	task chk_b(input got, input exp);
		chk_f(12'(got), 12'(exp));
	endtask
	task stop_test;
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (!rst_n) begin
			lat_cnt <= 0;
			flush_cur <= 1'b0;
			port_s <= 1'b0;
		end else if (phase_out == 4'h8) begin
			flush_cur <= !flush_cur && (is_br(exec_w) || is_sk(exec_w) && skip_cond_true);
			exec_w <= instr_valid ? instr_word : 14'h0000;
			lat_cnt <= lat_cnt + 1;
		end else if (phase_out == 4'h1) begin
			port_s <= file_is_port;
		end
		if (fetch_strobe)
			fetched <= 1'b1;
	end
	always @(negedge clock) begin
		if (rst_n && lat_cnt > 1 && phase_out == 4'h4) begin
			if (flush_cur) begin
				chk_b(second_cycle_nop, 1'b1);
				chk_b(dest_accum | dest_file, 1'b0);
			end else begin
				chk_b(second_cycle_nop, 1'b0);
				chk_f(12'(instr_class), 12'(exec_w[13:12]));
				chk_b(option_load, exec_w == 14'h0062);
				chk_b(tristate_load_instruction, exec_w >= 14'h0065 && exec_w <= 14'h0067);
				if (!is_sk(exec_w))
					chk_b(pc_change, is_br(exec_w));
				case (exec_w[13:12])
					2'h0: begin
						chk_f({1'b0, byte_op, file_addr}, {1'b0, exec_w[11:8], exec_w[6:0]});
						chk_b(use_pin_source, port_s && exec_w[11:7] != 5'h00);
						if (exec_w[11:7] != 5'h00) begin
							chk_b(dest_file, exec_w[7]);
							chk_b(dest_accum, !exec_w[7]);
						end
					end
					2'h1: begin
						chk_f({bit_op, bit_sel, file_addr}, exec_w[11:0]);
						chk_b(use_pin_source, port_s && !exec_w[11]);
					end
					2'h2: begin
						chk_f(12'(literal11), 12'(exec_w[10:0]));
						chk_b(use_pin_source, 1'b0);
					end
					default: chk_f(12'({dest_accum, 2'h0, literal8}), 12'({1'b1, 2'h0, exec_w[7:0]}));
				endcase
			end
		end
	end
	initial begin
		error_cnt = 0;
		comparisons = 0;
		lfsr = 16'h61E7;
		{rst_n, skip_cond_true, file_is_port, idle, fetched, flush_cur, lat_cnt, n} = 0;
		prescaler_to_timer = 1'b1;
		exec_w = 14'h0000;
		next_word = 14'h0000;
		// Option, tristate, returns, timer-zero write-back, skips, goto and don't-care forms.
		corner = '{14'h0062, 14'h0065, 14'h0066, 14'h0067, 14'h0008, 14'h0009, 14'h0781,
			14'h0B7F, 14'h1F80, 14'h2FFF, 14'h37FF, 14'h0060, 14'h3E00, 14'h0080};
		repeat (12) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		for (i = 0; i < 1600; i = i + 1) begin
			@(negedge clock);
			lfsr = lfsr_step(lfsr);
			skip_cond_true = lfsr[3];
			file_is_port = lfsr[7];
			idle = i >= 800 && i < 840;
			// The prescaler owner moves only while idle words run, so no write-back straddles it.
			if (i == 820)
				prescaler_to_timer = 1'b0;
			if (fetched) begin
				fetched = 1'b0;
				w = n < 14 ? corner[n] : lfsr_step(lfsr);
				// A write to the low program counter byte would branch unseen by the model.
				if (!w[13] && w[6:0] == 7'h02)
					w[0] = 1'b1;
				next_word = w;
				n = n + 1;
			end
		end
		chk_b(n > 150, 1'b1);
		stop_test;
	end
endmodule
